// >>> src/cpmc_charge_pump.sv
// Implementation choice: the strobed register port.
`include "cpmc_map.svh"
`timescale 1ns/100ps
`default_nettype none

module cpmc_charge_pump (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [`CPMC_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic supplyAboveThreshold,
    input wire logic pumpSteady,
    input wire logic converterEnable,
    output logic pumpEnable,
    output logic irq
);
    import cpmc_pkg::*;

    // =================================================================
    // state
    typedef struct packed {
        logic [1:0] syncThr;
        logic [1:0] syncRdy;
        cpmc_mode_t mode;
        logic pumpEn;
        logic thrPrev;
        logic rdyPrev;
        logic [`CPMC_EV_N-1:0] irqStat;
        logic [`CPMC_EV_N-1:0] irqMask;
        logic [7:0] rdData;
    } cpmc_state_t;

    cpmc_state_t state_q;
    cpmc_state_t state_d;

    logic aboveThr;
    logic steady;
    logic wantPump;
    logic [`CPMC_EV_N-1:0] events;
    logic [`CPMC_EV_N-1:0] clrMask;

    // synchronised copies; stage 0 is read only by stage 1
    assign aboveThr = state_q.syncThr[1];
    assign steady = state_q.syncRdy[1];

    // =================================================================
    // pump enable decision
    always_comb begin
        case (state_q.mode)
            CPMC_MODE_ON: wantPump = 1'h1;
            CPMC_MODE_AUTO: wantPump = !aboveThr;
            // converter gates the comparator; either going away drops the pump
            CPMC_MODE_GATED: wantPump = converterEnable && !aboveThr;
            CPMC_MODE_OFF: wantPump = 1'h0;
            default: wantPump = 1'h0;
        endcase
    end

    // =================================================================
    // next state
    always_comb begin
        state_d = state_q;
        state_d.syncThr = {state_q.syncThr[0], supplyAboveThreshold};
        state_d.syncRdy = {state_q.syncRdy[0], pumpSteady};
        state_d.pumpEn = wantPump;
        state_d.thrPrev = aboveThr;
        state_d.rdyPrev = steady;

        events = '0;
        events[`CPMC_EV_PUMP_ON] = wantPump && !state_q.pumpEn;
        events[`CPMC_EV_PUMP_OFF] = !wantPump && state_q.pumpEn;
        events[`CPMC_EV_STEADY] = steady && !state_q.rdyPrev;
        events[`CPMC_EV_THRESH] = aboveThr != state_q.thrPrev;

        clrMask = '0;
        if (regWrite) begin
            case (regAddr)
                // only the mode field is writable
                `CPMC_PUMP_CTRL_OFS: begin
                    state_d.mode = cpmc_mode_t'(
                        regWrData[`CPMC_MODE_HI:`CPMC_MODE_LO]);
                end
                `CPMC_IRQ_STAT_OFS: clrMask = regWrData[`CPMC_EV_N-1:0];
                `CPMC_IRQ_MASK_OFS: state_d.irqMask = regWrData[`CPMC_EV_N-1:0];
                default: ;
            endcase
        end
        // set wins over a same-cycle clear
        state_d.irqStat = (state_q.irqStat & ~clrMask) | events;

        state_d.rdData = 8'h00;
        if (regRead) begin
            case (regAddr)
                `CPMC_PUMP_CTRL_OFS: begin
                    state_d.rdData[`CPMC_MODE_HI:`CPMC_MODE_LO] = state_q.mode;
                    state_d.rdData[`CPMC_THRESH_BIT] = aboveThr;
                    state_d.rdData[`CPMC_STEADY_BIT] = steady;
                end
                `CPMC_IRQ_STAT_OFS: state_d.rdData[`CPMC_EV_N-1:0] = state_q.irqStat;
                `CPMC_IRQ_MASK_OFS: state_d.rdData[`CPMC_EV_N-1:0] = state_q.irqMask;
                default: state_d.rdData = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // =================================================================
    // registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= '{syncThr: 2'h0, syncRdy: 2'h0, mode: CPMC_MODE_OFF,
                         pumpEn: 1'h0, thrPrev: 1'h0, rdyPrev: 1'h0,
                         irqStat: '0, irqMask: '0, rdData: 8'h00};
        end else begin
            state_q <= state_d;
        end
    end

    // registered enable: one cycle behind the decision, glitch free to the analog core
    assign pumpEnable = state_q.pumpEn;
    assign regRdData = state_q.rdData;
    assign irq = |(state_q.irqStat & state_q.irqMask);

    // =================================================================
    // checks
    chk_on_mode_enable: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_ON |-> pumpEnable)
        else $error("pump enable low in always-on mode");

    chk_auto_mode_follows: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_AUTO |-> pumpEnable == !$past(aboveThr))
        else $error("auto mode enable does not follow threshold");

    chk_gated_mode_needs: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_GATED && !$past(converterEnable) |-> !pumpEnable)
        else $error("gated mode enable without converter");

    chk_gated_drop_fast: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_GATED
        |-> pumpEnable == ($past(converterEnable) && !$past(aboveThr)))
        else $error("gated mode enable does not follow converter and supply");

    chk_off_mode_low: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_OFF |-> !pumpEnable)
        else $error("pump enabled in off mode");

    chk_thresh_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == `CPMC_PUMP_CTRL_OFS
        |=> regRdData[`CPMC_THRESH_BIT] == $past(aboveThr))
        else $error("threshold status read wrong");

    chk_ready_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == `CPMC_PUMP_CTRL_OFS
        |=> regRdData[`CPMC_STEADY_BIT] == $past(steady))
        else $error("ready status read wrong");

    chk_mode_write: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == `CPMC_PUMP_CTRL_OFS
        |=> state_q.mode == $past(regWrData[`CPMC_MODE_HI:`CPMC_MODE_LO]))
        else $error("mode write not stored");

    chk_sync_delay: assert property (@(posedge clock) disable iff (!rst_n)
        aboveThr == $past(supplyAboveThreshold, 2))
        else $error("threshold synchroniser depth wrong");

    chk_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n)
        $past(regRead) && $past(regAddr) == `CPMC_PUMP_CTRL_OFS |-> regRdData[5:2] == 4'h0)
        else $error("reserved bits read nonzero");

    // =================================================================
    // enable decision, further cases
    chk_auto_off_above: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_AUTO && $past(aboveThr)
        |-> !pumpEnable)
        else $error("auto mode enable while supply is high");

    chk_gated_on_below: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_GATED && $past(converterEnable) && !$past(aboveThr)
        |-> pumpEnable)
        else $error("gated mode enable missing with converter on");

    chk_gated_off_above: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_GATED && $past(aboveThr)
        |-> !pumpEnable)
        else $error("gated mode enable while supply is high");

    chk_gated_conv_drop: assert property (@(posedge clock) disable iff (!rst_n)
        state_q.mode == CPMC_MODE_GATED && !converterEnable
        |=> !pumpEnable)
        else $error("gated mode enable kept after converter off");

    chk_on_enable_stable: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_q.mode) == CPMC_MODE_ON && $past(state_q.mode, 2) == CPMC_MODE_ON
        |-> $stable(pumpEnable))
        else $error("pump enable moved in always-on mode");

    chk_enable_source: assert property (@(posedge clock) disable iff (!rst_n)
        pumpEnable
        |-> $past(state_q.mode) != CPMC_MODE_OFF)
        else $error("pump enable without a mode that allows it");

    // reset is asynchronous, so these look at the first edge after release
    chk_reset_mode_off: assert property (@(posedge clock)
        $rose(rst_n)
        |-> state_q.mode == CPMC_MODE_OFF && !pumpEnable)
        else $error("mode or enable not cleared by reset");

    chk_reset_outputs: assert property (@(posedge clock)
        $rose(rst_n)
        |-> regRdData == 8'h00 && !irq)
        else $error("outputs not cleared by reset");

    // =================================================================
    // synchroniser, status reads and register holds
    chk_steady_sync: assert property (@(posedge clock) disable iff (!rst_n)
        steady == $past(pumpSteady, 2))
        else $error("steady synchroniser depth wrong");

    chk_thresh_pin_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == `CPMC_PUMP_CTRL_OFS
        |=> regRdData[`CPMC_THRESH_BIT] == $past(supplyAboveThreshold, 3))
        else $error("threshold status does not match the pin three edges back");

    chk_mode_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == `CPMC_PUMP_CTRL_OFS
        |=> regRdData[`CPMC_MODE_HI:`CPMC_MODE_LO] == $past(state_q.mode))
        else $error("mode field read wrong");

    chk_mode_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !(regWrite && regAddr == `CPMC_PUMP_CTRL_OFS)
        |=> $stable(state_q.mode))
        else $error("mode changed without a control write");

    chk_unmapped_write: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr != `CPMC_PUMP_CTRL_OFS && regAddr != `CPMC_IRQ_STAT_OFS
        && regAddr != `CPMC_IRQ_MASK_OFS |=> $stable(state_q.mode) && $stable(state_q.irqMask))
        else $error("unmapped write changed a register");

    // =================================================================
    // register bus
    chk_read_idle_zero: assert property (@(posedge clock) disable iff (!rst_n)
        !regRead
        |=> regRdData == 8'h00)
        else $error("read data not zero outside the read cycle");

    chk_unmapped_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr != `CPMC_PUMP_CTRL_OFS && regAddr != `CPMC_IRQ_STAT_OFS
        && regAddr != `CPMC_IRQ_MASK_OFS |=> regRdData == 8'h00)
        else $error("unmapped read not zero");

    chk_stat_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == `CPMC_IRQ_STAT_OFS
        |=> regRdData == {4'h0, $past(state_q.irqStat)})
        else $error("status register read wrong");

    chk_mask_read: assert property (@(posedge clock) disable iff (!rst_n)
        regRead && regAddr == `CPMC_IRQ_MASK_OFS
        |=> regRdData == {4'h0, $past(state_q.irqMask)})
        else $error("mask register read wrong");

    // =================================================================
    // interrupts
    chk_on_event_set: assert property (@(posedge clock) disable iff (!rst_n)
        wantPump && !state_q.pumpEn
        |=> state_q.irqStat[`CPMC_EV_PUMP_ON])
        else $error("pump on event not recorded");

    chk_off_event_set: assert property (@(posedge clock) disable iff (!rst_n)
        !wantPump && state_q.pumpEn
        |=> state_q.irqStat[`CPMC_EV_PUMP_OFF])
        else $error("pump off event not recorded");

    chk_steady_event_set: assert property (@(posedge clock) disable iff (!rst_n)
        steady && !state_q.rdyPrev
        |=> state_q.irqStat[`CPMC_EV_STEADY])
        else $error("steady event not recorded");

    chk_thresh_event_set: assert property (@(posedge clock) disable iff (!rst_n)
        aboveThr != state_q.thrPrev
        |=> state_q.irqStat[`CPMC_EV_THRESH])
        else $error("threshold event not recorded");

    // an event in the clearing cycle must survive the clear
    chk_clear_set_wins: assert property (@(posedge clock) disable iff (!rst_n)
        events[`CPMC_EV_PUMP_ON] && regWrite && regAddr == `CPMC_IRQ_STAT_OFS
        |=> state_q.irqStat[`CPMC_EV_PUMP_ON])
        else $error("clear beat a same-cycle event");

    chk_stat_clear: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == `CPMC_IRQ_STAT_OFS && events == '0
        |=> state_q.irqStat == ($past(state_q.irqStat) & ~$past(regWrData[`CPMC_EV_N-1:0])))
        else $error("write one to clear failed");

    chk_stat_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        !(regWrite && regAddr == `CPMC_IRQ_STAT_OFS)
        |=> (state_q.irqStat & $past(state_q.irqStat)) == $past(state_q.irqStat))
        else $error("status bit lost without a clear");

    chk_mask_write: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == `CPMC_IRQ_MASK_OFS
        |=> state_q.irqMask == $past(regWrData[`CPMC_EV_N-1:0]))
        else $error("mask write not stored");

    chk_mask_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !(regWrite && regAddr == `CPMC_IRQ_MASK_OFS)
        |=> $stable(state_q.irqMask))
        else $error("mask changed without a write");

    chk_irq_masked_off: assert property (@(posedge clock) disable iff (!rst_n)
        regWrite && regAddr == `CPMC_IRQ_MASK_OFS && regWrData[`CPMC_EV_N-1:0] == '0
        |=> !irq)
        else $error("interrupt raised with every source masked");

    chk_off_mode_quiet: assert property (@(posedge clock) disable iff (!rst_n)
        state_q.mode == CPMC_MODE_OFF && !state_q.pumpEn
        |=> !state_q.pumpEn)
        else $error("pump turned on in off mode");

endmodule // cpmc_charge_pump

`default_nettype wire

// >>> src/cpmc_map.svh
`ifndef CPMC_MAP_SVH
`define CPMC_MAP_SVH

// =====================================================================
// register map
`define CPMC_ADDR_W 12
`define CPMC_PUMP_CTRL_OFS 12'h09a
`define CPMC_IRQ_STAT_OFS 12'h0a0
`define CPMC_IRQ_MASK_OFS 12'h0a1
`define CPMC_PUMP_CTRL_RST 8'h00
`define CPMC_IRQ_RST 8'h00

// =====================================================================
// field positions
`define CPMC_MODE_HI 7
`define CPMC_MODE_LO 6
`define CPMC_THRESH_BIT 1
`define CPMC_STEADY_BIT 0

// =====================================================================
// interrupt status bits
`define CPMC_EV_PUMP_ON 0
`define CPMC_EV_PUMP_OFF 1
`define CPMC_EV_STEADY 2
`define CPMC_EV_THRESH 3
`define CPMC_EV_N 4

`endif

// >>> src/cpmc_pkg.sv
package cpmc_pkg;
    typedef enum logic [1:0] {
        CPMC_MODE_OFF = 2'b00,
        CPMC_MODE_GATED = 2'b01,
        CPMC_MODE_AUTO = 2'b10,
        CPMC_MODE_ON = 2'b11
    } cpmc_mode_t;
endpackage

// >>> sim/cpmc_pump_model.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// pump core and supply comparator stand-in
module cpmc_pump_model (
    input wire logic clock,
    input wire logic pumpEnable,
    input wire logic vddHigh,
    output logic supplyAboveThreshold,
    output logic pumpSteady
);
    int unsigned settle = 0;

    // steady only after some cycles of drive, lost at once when switched off
    always @(posedge clock) begin
        settle <= pumpEnable ? settle + 1 : 0;
    end
    assign pumpSteady = settle > 3;
    assign supplyAboveThreshold = vddHigh;
endmodule // cpmc_pump_model

`default_nettype wire

// >>> sim/test_cpmc_charge_pump.sv
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// bench
module test_cpmc_charge_pump;
    logic clock, rst_n, regWrite, regRead, vddHigh, conv, en;
    logic supplyAboveThreshold, pumpSteady, pumpEnable, irq;
    logic readSeen = 1'b0;
    logic [11:0] regAddr;
    logic [7:0] regWrData, regRdData;
    logic [15:0] lfsr = 16'h5a67;
    logic [7:0] expQ[$];
    int miscompares = 0, n_checks = 0, cycles = 0;

    cpmc_charge_pump u_dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .supplyAboveThreshold(supplyAboveThreshold),
        .pumpSteady(pumpSteady), .converterEnable(conv), .pumpEnable(pumpEnable), .irq(irq));
    cpmc_pump_model u_pump (.clock(clock), .pumpEnable(pumpEnable), .vddHigh(vddHigh),
        .supplyAboveThreshold(supplyAboveThreshold), .pumpSteady(pumpSteady));

    function automatic logic [15:0] nextRand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic compare(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // a spare cycle after each strobe keeps every drive to one per time step
    task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
        regWrite <= w;
        regRead <= !w;
        regAddr <= a;
        regWrData <= d;
        @(posedge clock);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        @(posedge clock);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        expQ.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    always @(posedge clock) begin
        readSeen <= regRead;
        if (readSeen) compare("read data", expQ.pop_front(), regRdData);
    end

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        rst_n = 1'b0; regWrite = 1'b0; regRead = 1'b0; regAddr = 12'h000;
        regWrData = 8'h00; vddHigh = 1'b0; conv = 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(12'h09a, 8'h00);
        // every mode against every supply and converter state
        for (int i = 0; i < 16; i++) begin
            lfsr = nextRand(lfsr);
            vddHigh <= i[0];
            conv <= i[1];
            bus(1'b1, 12'h09a, {i[3:2], lfsr[5:0]});
            repeat (10) @(posedge clock);
            en = (i[3:2] == 2'b11) || (i[3:2] == 2'b10 && !i[0]) ||
                (i[3:2] == 2'b01 && !i[0] && i[1]);
            compare("pump enable", {7'h00, en}, {7'h00, pumpEnable});
            rd(12'h09a, {i[3:2], 4'h0, i[0], en});
        end
        $display("mode test done");
        bus(1'b1, 12'h09a, 8'h00);
        repeat (10) @(posedge clock);
        compare("pump off", 8'h00, {7'h00, pumpEnable});
        bus(1'b1, 12'h0a0, 8'h0f);
        rd(12'h0a0, 8'h00);
        bus(1'b1, 12'h09a, 8'hc0);
        repeat (12) @(posedge clock);
        rd(12'h0a0, 8'h05);
        bus(1'b1, 12'h0a1, 8'h02);
        compare("irq masked", 8'h00, {7'h00, irq});
        bus(1'b1, 12'h0a1, 8'h01);
        compare("irq raised", 8'h01, {7'h00, irq});
        bus(1'b1, 12'h0a0, 8'h01);
        compare("irq cleared", 8'h00, {7'h00, irq});
        rd(12'h0a0, 8'h04);
        rd(12'h0a1, 8'h01);
        rd(12'h0ff, 8'h00);
        repeat (2) @(posedge clock);
        $display("interrupt test done");
        end_of_test();
    end
endmodule // test_cpmc_charge_pump

`default_nettype wire
